// file: common/sled_cfg.svh
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH

// clock and timing base
`define SLED_CLK_HZ           10000000
`define SLED_UNIT_MS          50
`define SLED_UNIT_CYCLES      (`SLED_CLK_HZ / 1000 * `SLED_UNIT_MS)
`define SLED_STAT_SPACE_MS    100
`define SLED_STAT_PAUSE_MS    500
`define SLED_STAT_ON_UNITS    (`SLED_STAT_SPACE_MS / 2 / `SLED_UNIT_MS)
`define SLED_STAT_OFF_UNITS   (`SLED_STAT_SPACE_MS / 2 / `SLED_UNIT_MS)
`define SLED_STAT_PAUSE_UNITS (`SLED_STAT_PAUSE_MS / `SLED_UNIT_MS)
`define SLED_FLASH_ON_MS      200
`define SLED_FLASH_PAUSE_MS   1000
`define SLED_BUS_ON_UNITS     (`SLED_FLASH_ON_MS / `SLED_UNIT_MS)
`define SLED_BUS_OFF_UNITS    (`SLED_FLASH_ON_MS / `SLED_UNIT_MS)
`define SLED_BUS_PAUSE_UNITS  (`SLED_FLASH_PAUSE_MS / `SLED_UNIT_MS)
`define SLED_BLINK_MS         200
`define SLED_BLINK_UNITS      (`SLED_BLINK_MS / `SLED_UNIT_MS)

// register byte offsets
`define SLED_OFS_CTRL   8'h00
`define SLED_OFS_BUSV   8'h04
`define SLED_OFS_ERRSET 8'h08
`define SLED_OFS_ERRCLR 8'h0C
`define SLED_OFS_CAN    8'h10
`define SLED_OFS_CANCNT 8'h14
`define SLED_OFS_ETH    8'h18
`define SLED_OFS_STAT   8'h1C

// field positions
`define SLED_CTRL_EN    0
`define SLED_CTRL_FW    1
`define SLED_CTRL_START 2
`define SLED_CAN_WARN   4
`define SLED_CAN_GUARD  5
`define SLED_CAN_SYNC   6
`define SLED_ETH_ERR    4
`define SLED_CNT_RX_LSB 16
`define SLED_BUSV_LVL_LSB 16

// reset values
`define SLED_CTRL_RST   3'h0
`define SLED_ERR_RST    7'h00
`define SLED_CAN_RST    7'h00
`define SLED_CNT_RST    9'h000
`define SLED_ETH_RST    3'h0
`define SLED_VOLT_RST   16'h0000

// error codes and counter limits
`define SLED_CODE_NONE    4'h0
`define SLED_CODE_OVERCUR 4'h3
`define SLED_CODE_FEEDBK  4'h5
`define SLED_CODE_PHASE   4'hB
`define SLED_CODE_OTHER   4'hC
`define SLED_PASSIVE_LIM  9'h07F
`define SLED_BUSOFF_LIM   9'h0FF

`endif

// file: common/sled_pkg.sv
package sled_pkg;
	typedef logic [3:0] sled_code_t;
	typedef logic [6:0] sled_err_t;
	typedef enum logic [2:0] {
		CAN_INIT     = 3'b000,
		CAN_STOPPED  = 3'b001,
		CAN_PREOP    = 3'b010,
		CAN_OPER     = 3'b011,
		CAN_DOWNLOAD = 3'b100,
		CAN_AUTOBAUD = 3'b101
	} sled_can_state_t;
	typedef enum logic [2:0] {
		ETH_NOTACT  = 3'b000,
		ETH_PREOP1  = 3'b001,
		ETH_PREOP2  = 3'b010,
		ETH_READY   = 3'b011,
		ETH_STOPPED = 3'b100,
		ETH_BASIC   = 3'b101,
		ETH_OPER    = 3'b110
	} sled_eth_state_t;
	typedef enum logic [1:0] {
		FL_PAUSE = 2'b00,
		FL_ON    = 2'b01,
		FL_OFF   = 2'b10
	} sled_flash_phase_t;
endpackage

// file: common/sled_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sled_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface
`default_nettype wire

// file: hw/sled_err_code.sv
`timescale 1ns/100ps
`default_nettype none
`include "sled_cfg.svh"
module sled_err_code
	import sled_pkg::*;
(
	// latched errors: overcurrent, feedback, phase search, four others
	input  wire sled_err_t  errBits,
	// lowest code present
	output var sled_code_t  code
);
	always_comb begin
		if (errBits[0]) begin
			code = `SLED_CODE_OVERCUR;
		end else if (errBits[1]) begin
			code = `SLED_CODE_FEEDBK;
		end else if (errBits[2]) begin
			code = `SLED_CODE_PHASE;
		end else if (|errBits[6:3]) begin
			code = `SLED_CODE_OTHER;
		end else begin
			code = `SLED_CODE_NONE;
		end
	end
endmodule
`default_nettype wire

// file: hw/sled_flash_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sled_flash_gen
	import sled_pkg::*;
#(
	parameter int ON_UNITS    = 1,
	parameter int OFF_UNITS   = 1,
	parameter int PAUSE_UNITS = 1
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// time base
	sled_tick_if.snk        tickIf,
	// flashes per group, zero for dark
	input  wire logic [3:0] count,
	output logic            led
);
	localparam logic [7:0] ON_LAST    = 8'(ON_UNITS - 1);
	localparam logic [7:0] OFF_LAST   = 8'(OFF_UNITS - 1);
	localparam logic [7:0] PAUSE_LAST = 8'(PAUSE_UNITS - 1);

	generate
		if (ON_UNITS < 1 || OFF_UNITS < 1 || PAUSE_UNITS < 1 ||
		    ON_UNITS > 256 || OFF_UNITS > 256 || PAUSE_UNITS > 256) begin
			$error("flash unit counts must lie in 1..256");
		end
	endgenerate

	sled_flash_phase_t phase_reg;
	logic [7:0]        unit_reg;
	logic [3:0]        left_reg;

	// count is sampled only at the end of a pause so a group never truncates
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= FL_PAUSE;
			unit_reg  <= 8'h00;
			left_reg  <= 4'h0;
		end else if (tickIf.tick) begin
			case (phase_reg)
				FL_PAUSE: begin
					unit_reg <= (unit_reg == PAUSE_LAST) ? 8'h00 : unit_reg + 8'h01;
					if (unit_reg == PAUSE_LAST && count != 4'h0) begin
						phase_reg <= FL_ON;
						left_reg  <= count;
					end
				end
				FL_ON: begin
					unit_reg <= (unit_reg == ON_LAST) ? 8'h00 : unit_reg + 8'h01;
					if (unit_reg == ON_LAST) begin
						phase_reg <= FL_OFF;
					end
				end
				FL_OFF: begin
					unit_reg <= (unit_reg == OFF_LAST) ? 8'h00 : unit_reg + 8'h01;
					if (unit_reg == OFF_LAST) begin
						left_reg  <= left_reg - 4'h1;
						phase_reg <= (left_reg > 4'h1) ? FL_ON : FL_PAUSE;
					end
				end
				default: begin
					phase_reg <= FL_PAUSE;
					unit_reg  <= 8'h00;
				end
			endcase
		end
	end

	assign led = (phase_reg == FL_ON);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	flashEnds_a: assert property (
		tickIf.tick && phase_reg == FL_ON && unit_reg == ON_LAST
		|=> phase_reg == FL_OFF)
		else $error("flash did not end after its on time");
	groupLoad_a: assert property (
		phase_reg == FL_PAUSE ##1 phase_reg == FL_ON
		|-> left_reg == $past(count))
		else $error("group started with a count other than sampled");
	noTruncate_a: assert property (
		phase_reg != FL_PAUSE && !(tickIf.tick && phase_reg == FL_OFF &&
		unit_reg == OFF_LAST) |=> phase_reg != FL_PAUSE)
		else $error("flash group cut short");
endmodule
`default_nettype wire

// file: hw/sled_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sled_cfg.svh"
module sled_sequencer
	import sled_pkg::*;
#(
	parameter int TICK_CYCLES = `SLED_UNIT_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// error trip pulses from the drive logic, same clock
	input  wire sled_err_t   errEvent,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// indicators
	output logic             statusGreen,
	output logic             statusRed,
	output logic             canGreen,
	output logic             canRed,
	output logic             ethGreen,
	output logic             ethRed
);
	generate
		if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) begin
			$error("TICK_CYCLES must lie in 2..16777215");
		end
	endgenerate

	localparam logic [23:0] TICK_LAST  = 24'(TICK_CYCLES - 1);
	localparam logic [7:0]  BLINK_LAST = 8'(`SLED_BLINK_UNITS - 1);

	// ---- bus slave ----
	logic       wrPend_reg;
	logic [7:0] wrAddr_reg;
	logic       addrPhase;

	// only whole-word transfers are taken; others complete with no effect
	assign addrPhase = hsel && hready && htrans[1] && hsize == 3'h2;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end else begin
			wrPend_reg <= addrPhase && hwrite;
			if (addrPhase) begin
				wrAddr_reg <= haddr[7:0];
			end
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	function automatic logic wrHit(input logic [7:0] ofs);
		wrHit = wrPend_reg && wrAddr_reg == ofs;
	endfunction

	// ---- software registers ----
	logic [2:0]  ctrl_reg;
	logic [15:0] busVolts_reg;
	logic [15:0] uvLevel_reg;
	sled_err_t   errLatch_reg;
	sled_err_t   errLatch_next;
	logic [6:0]  canCfg_reg;
	logic [8:0]  txErr_reg;
	logic [8:0]  rxErr_reg;
	logic [2:0]  ethState_reg;
	logic        ethErr_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= `SLED_CTRL_RST;
		end else if (wrHit(`SLED_OFS_CTRL)) begin
			ctrl_reg <= hwdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busVolts_reg <= `SLED_VOLT_RST;
			uvLevel_reg  <= `SLED_VOLT_RST;
		end else if (wrHit(`SLED_OFS_BUSV)) begin
			busVolts_reg <= hwdata[15:0];
			uvLevel_reg  <= hwdata[`SLED_BUSV_LVL_LSB +: 16];
		end
	end

	// a trip arriving with a clear is kept: set wins
	always_comb begin
		errLatch_next = errLatch_reg;
		if (wrHit(`SLED_OFS_ERRCLR)) begin
			errLatch_next = errLatch_next & ~hwdata[6:0];
		end
		if (wrHit(`SLED_OFS_ERRSET)) begin
			errLatch_next = errLatch_next | hwdata[6:0];
		end
		errLatch_next = errLatch_next | errEvent;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			errLatch_reg <= `SLED_ERR_RST;
		end else begin
			errLatch_reg <= errLatch_next;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			canCfg_reg <= `SLED_CAN_RST;
			txErr_reg  <= `SLED_CNT_RST;
			rxErr_reg  <= `SLED_CNT_RST;
		end else begin
			if (wrHit(`SLED_OFS_CAN)) begin
				canCfg_reg <= {hwdata[6:4], 1'b0, hwdata[2:0]};
			end
			if (wrHit(`SLED_OFS_CANCNT)) begin
				txErr_reg <= hwdata[8:0];
				rxErr_reg <= hwdata[`SLED_CNT_RX_LSB +: 9];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ethState_reg <= `SLED_ETH_RST;
			ethErr_reg   <= 1'b0;
		end else if (wrHit(`SLED_OFS_ETH)) begin
			ethState_reg <= hwdata[2:0];
			ethErr_reg   <= hwdata[`SLED_ETH_ERR];
		end
	end

	logic driveEn;
	logic fwUpdate;
	logic startDone;
	assign driveEn   = ctrl_reg[`SLED_CTRL_EN];
	assign fwUpdate  = ctrl_reg[`SLED_CTRL_FW];
	assign startDone = ctrl_reg[`SLED_CTRL_START];

	// ---- derived conditions ----
	sled_code_t errCode;
	logic       uvTrip_reg;
	logic       busOff;
	logic       busPassive;

	sled_err_code errCodeMap (
		.errBits (errLatch_reg),
		.code    (errCode)
	);

	// live level: disabling the drive withdraws the warning
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uvTrip_reg <= 1'b0;
		end else begin
			uvTrip_reg <= driveEn && busVolts_reg < uvLevel_reg;
		end
	end

	assign busOff     = txErr_reg > `SLED_BUSOFF_LIM ||
	                    rxErr_reg > `SLED_BUSOFF_LIM;
	assign busPassive = txErr_reg > `SLED_PASSIVE_LIM ||
	                    rxErr_reg > `SLED_PASSIVE_LIM;

	// ---- time base ----
	sled_tick_if tickIf ();
	logic [23:0] tickCnt_reg;
	logic [7:0]  blinkCnt_reg;
	logic        flickPh_reg;
	logic        blinkPh_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tickCnt_reg <= 24'h000000;
			tickIf.tick <= 1'b0;
		end else begin
			tickIf.tick <= tickCnt_reg == TICK_LAST;
			tickCnt_reg <= (tickCnt_reg == TICK_LAST) ? 24'h000000
			             : tickCnt_reg + 24'h000001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blinkCnt_reg <= 8'h00;
			flickPh_reg  <= 1'b0;
			blinkPh_reg  <= 1'b0;
		end else if (tickIf.tick) begin
			flickPh_reg  <= ~flickPh_reg;
			blinkCnt_reg <= (blinkCnt_reg == BLINK_LAST) ? 8'h00
			              : blinkCnt_reg + 8'h01;
			if (blinkCnt_reg == BLINK_LAST) begin
				blinkPh_reg <= ~blinkPh_reg;
			end
		end
	end

	// ---- counted flash generators ----
	logic [3:0] canGreenCnt;
	logic [3:0] canRedCnt;
	logic [3:0] ethGreenCnt;
	logic       statFlash;
	logic       canGreenFlash;
	logic       canRedFlash;
	logic       ethGreenFlash;

	assign canGreenCnt = (canCfg_reg[2:0] == CAN_STOPPED)  ? 4'h1 :
	                     (canCfg_reg[2:0] == CAN_DOWNLOAD) ? 4'h3 : 4'h0;
	assign canRedCnt   = canCfg_reg[`SLED_CAN_SYNC]  ? 4'h3 :
	                     canCfg_reg[`SLED_CAN_GUARD] ? 4'h2 :
	                     canCfg_reg[`SLED_CAN_WARN]  ? 4'h1 : 4'h0;
	assign ethGreenCnt = (ethState_reg == ETH_PREOP1) ? 4'h1 :
	                     (ethState_reg == ETH_PREOP2) ? 4'h2 :
	                     (ethState_reg == ETH_READY)  ? 4'h3 : 4'h0;

	sled_flash_gen #(
		.ON_UNITS    (`SLED_STAT_ON_UNITS),
		.OFF_UNITS   (`SLED_STAT_OFF_UNITS),
		.PAUSE_UNITS (`SLED_STAT_PAUSE_UNITS)
	) statGen (
		.clk    (clk),
		.resetn (resetn),
		.tickIf (tickIf),
		.count  (errCode),
		.led    (statFlash)
	);

	sled_flash_gen #(
		.ON_UNITS    (`SLED_BUS_ON_UNITS),
		.OFF_UNITS   (`SLED_BUS_OFF_UNITS),
		.PAUSE_UNITS (`SLED_BUS_PAUSE_UNITS)
	) canGreenGen (
		.clk    (clk),
		.resetn (resetn),
		.tickIf (tickIf),
		.count  (canGreenCnt),
		.led    (canGreenFlash)
	);

	sled_flash_gen #(
		.ON_UNITS    (`SLED_BUS_ON_UNITS),
		.OFF_UNITS   (`SLED_BUS_OFF_UNITS),
		.PAUSE_UNITS (`SLED_BUS_PAUSE_UNITS)
	) canRedGen (
		.clk    (clk),
		.resetn (resetn),
		.tickIf (tickIf),
		.count  (canRedCnt),
		.led    (canRedFlash)
	);

	sled_flash_gen #(
		.ON_UNITS    (`SLED_BUS_ON_UNITS),
		.OFF_UNITS   (`SLED_BUS_OFF_UNITS),
		.PAUSE_UNITS (`SLED_BUS_PAUSE_UNITS)
	) ethGreenGen (
		.clk    (clk),
		.resetn (resetn),
		.tickIf (tickIf),
		.count  (ethGreenCnt),
		.led    (ethGreenFlash)
	);

	// ---- status indicator ----
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			statusGreen <= 1'b0;
			statusRed   <= 1'b0;
		end else if (fwUpdate) begin
			statusGreen <= flickPh_reg;
			statusRed   <= 1'b0;
		end else if (errCode != `SLED_CODE_NONE) begin
			statusGreen <= 1'b0;
			statusRed   <= statFlash;
		end else if (uvTrip_reg) begin
			statusGreen <= ~blinkPh_reg;
			statusRed   <= blinkPh_reg;
		end else begin
			statusGreen <= driveEn;
			statusRed   <= ~driveEn;
		end
	end

	// ---- fieldbus indicators, dark until startup completes ----
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			canGreen <= 1'b0;
			canRed   <= 1'b0;
		end else if (!startDone) begin
			canGreen <= 1'b0;
			canRed   <= 1'b0;
		end else begin
			case (canCfg_reg[2:0])
				CAN_STOPPED, CAN_DOWNLOAD: canGreen <= canGreenFlash;
				CAN_PREOP:    canGreen <= blinkPh_reg;
				CAN_OPER:     canGreen <= 1'b1;
				CAN_AUTOBAUD: canGreen <= flickPh_reg;
				default:      canGreen <= 1'b0;
			endcase
			if (canCfg_reg[2:0] == CAN_AUTOBAUD) begin
				canRed <= ~flickPh_reg;
			end else if (busOff) begin
				canRed <= 1'b1;
			end else begin
				canRed <= canRedFlash;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ethGreen <= 1'b0;
			ethRed   <= 1'b0;
		end else if (!startDone) begin
			ethGreen <= 1'b0;
			ethRed   <= 1'b0;
		end else begin
			case (ethState_reg)
				ETH_PREOP1, ETH_PREOP2, ETH_READY: ethGreen <= ethGreenFlash;
				ETH_STOPPED: ethGreen <= blinkPh_reg;
				ETH_BASIC:   ethGreen <= flickPh_reg;
				ETH_OPER:    ethGreen <= 1'b1;
				default:     ethGreen <= 1'b0;
			endcase
			ethRed <= ethErr_reg;
		end
	end

	// ---- read data, captured in the address phase ----
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h00000000;
		end else if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				`SLED_OFS_CTRL:   hrdata <= {29'h0, ctrl_reg};
				`SLED_OFS_BUSV:   hrdata <= {uvLevel_reg, busVolts_reg};
				`SLED_OFS_ERRSET,
				`SLED_OFS_ERRCLR: hrdata <= {25'h0, errLatch_reg};
				`SLED_OFS_CAN:    hrdata <= {25'h0, canCfg_reg};
				`SLED_OFS_CANCNT: hrdata <= {7'h0, rxErr_reg, 7'h0, txErr_reg};
				`SLED_OFS_ETH:    hrdata <= {27'h0, ethErr_reg, 1'b0, ethState_reg};
				`SLED_OFS_STAT:   hrdata <= {18'h0, ethRed, ethGreen, canRed,
				                  canGreen, statusRed, statusGreen, 1'b0,
				                  busPassive, busOff, uvTrip_reg, errCode};
				default:          hrdata <= 32'h00000000;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	greenRun_a: assert property (
		driveEn && !fwUpdate && errCode == 4'h0 && !uvTrip_reg
		|=> statusGreen && !statusRed)
		else $error("status not steady green while enabled");
	redIdle_a: assert property (
		!driveEn && !fwUpdate && errCode == 4'h0 && !uvTrip_reg
		|=> statusRed && !statusGreen)
		else $error("status not steady red while disabled");
	codeMap_a: assert property (
		(errLatch_reg[0] |-> errCode == 4'h3) and
		(errLatch_reg[1:0] == 2'b10 |-> errCode == 4'h5))
		else $error("overcurrent or feedback code wrong");
	codeRest_a: assert property (
		errLatch_reg[2:0] == 3'b000 && |errLatch_reg[6:3] |-> errCode == 4'hC)
		else $error("other error not code 12");
	tripKept_a: assert property (
		errEvent[0] |=> errLatch_reg[0] && errCode == 4'h3)
		else $error("new trip lost or not shown");
	uvAlternate_a: assert property (
		uvTrip_reg && errCode == 4'h0 && !fwUpdate
		|=> statusRed != statusGreen)
		else $error("undervoltage not alternating");
	uvEnabled_a: assert property (
		!driveEn |=> !uvTrip_reg)
		else $error("undervoltage raised while disabled");
	startDark_a: assert property (
		!startDone |=> !canGreen && !canRed && !ethGreen && !ethRed)
		else $error("bus indicators lit before startup");
	baudFlicker_a: assert property (
		startDone && canCfg_reg[2:0] == CAN_AUTOBAUD |=> canGreen != canRed)
		else $error("baud detection flicker not alternating");
	busOffRed_a: assert property (
		startDone && busOff && canCfg_reg[2:0] != CAN_AUTOBAUD |=> canRed [*1])
		else $error("bus-off red not steady");
	offLimit_a: assert property (
		(txErr_reg == 9'h100 |-> busOff) and
		(txErr_reg <= 9'h0FF && rxErr_reg <= 9'h0FF |-> !busOff))
		else $error("bus-off threshold wrong");
	ethError_a: assert property (
		startDone ##1 startDone |-> ethRed == $past(ethErr_reg))
		else $error("ethernet red does not follow error");
endmodule
`default_nettype wire

// file: verif/sled_led_obs.sv
`timescale 1ns/100ps
`default_nettype none
module sled_led_obs (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// watched lamp and shortest dark run taken as a pause
	input  wire logic       led,
	input  wire logic [7:0] gapMin,
	// last complete flash group
	output logic      [3:0] groupCnt,
	output logic      [7:0] lastGap,
	output logic            groupValid
);
	logic       ledReg;
	logic [7:0] lowRun;
	logic [3:0] curCnt;
	// a group is only known complete when the next one starts
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ledReg <= 1'b0;
			lowRun <= 8'h00;
			curCnt <= 4'h0;
			groupCnt <= 4'h0;
			lastGap <= 8'h00;
			groupValid <= 1'b0;
		end else begin
			ledReg <= led;
			groupValid <= 1'b0;
			if (led && !ledReg) begin
				lowRun <= 8'h00;
				if (lowRun >= gapMin) begin
					groupCnt <= curCnt;
					lastGap <= lowRun;
					groupValid <= 1'b1;
					curCnt <= 4'h1;
				end else begin
					curCnt <= curCnt + 4'h1;
				end
			end else if (!led && lowRun != 8'hFF) begin
				lowRun <= lowRun + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/status_led_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module status_led_sequencer_tb;
	import sled_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	sled_err_t   errEvent = 7'h00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  obsSel = 3'h0;
	logic [7:0]  gapMin = 8'h14;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [5:0]  leds;
	wire  [3:0]  obsCnt;
	wire  [7:0]  obsGap;
	wire         obsValid;
	int          miscompares = 0;
	int          totalChecks = 0;
	int          cyc = 0;
	always #50 clk = ~clk;
	// short tick keeps every pattern a few hundred cycles long
	sled_sequencer #(.TICK_CYCLES(4)) sled_sequencer_inst (.clk(clk),
		.resetn(resetn), .errEvent(errEvent), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.statusGreen(leds[0]), .statusRed(leds[1]),
		.canGreen(leds[2]), .canRed(leds[3]),
		.ethGreen(leds[4]), .ethRed(leds[5]));
	sled_led_obs sled_led_obs_inst (.clk(clk), .resetn(resetn),
		.led(leds[obsSel]), .gapMin(gapMin), .groupCnt(obsCnt),
		.lastGap(obsGap), .groupValid(obsValid));
	task automatic results();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r & m, e);
	endtask
	task automatic pulse(input sled_err_t b);
		errEvent <= b;
		@(posedge clk);
		errEvent <= 7'h00;
		@(posedge clk);
	endtask
	// third group after a change is the first that must be new
	task automatic grp(input logic [2:0] s, input logic [7:0] g,
			input logic [3:0] e);
		obsSel <= s;
		gapMin <= g;
		repeat (3) begin
			do @(posedge clk); while (obsValid !== 1'b1);
		end
		chk(obsCnt, e);
	endtask
	task automatic watch(input int s, input int p, input logic opp,
			input int lo, input int hi);
		int n;
		logic last;
		n = 0;
		repeat (20) @(posedge clk);
		last = leds[s];
		repeat (120) begin
			@(posedge clk);
			if (leds[s] !== last) n++;
			last = leds[s];
			if (opp) chk(leds[s] ^ leds[p], 1'b1);
		end
		chk(n >= lo && n <= hi, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rdc(8'h00, 32'hFFFFFFFF, 32'h0);
		rdc(8'h1C, 32'h7F, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rdc(8'h20, 32'hFFFFFFFF, 32'h0);
		chk(hresp, 1'b0);
		repeat (4) @(posedge clk);
		chk(leds[1:0], 2'b10);
		wr(8'h00, 32'h1);
		repeat (4) @(posedge clk);
		chk(leds[1:0], 2'b01);
		wr(8'h00, 32'h3);
		watch(0, 0, 1'b0, 10, 40);
		chk(leds[1], 1'b0);
		wr(8'h04, 32'h01000080);
		wr(8'h00, 32'h1);
		rdc(8'h1C, 32'h10, 32'h10);
		watch(0, 1, 1'b1, 2, 10);
		wr(8'h00, 32'h0);
		// undervoltage flag trails the enable bit by one cycle
		@(posedge clk);
		rdc(8'h1C, 32'h10, 32'h0);
		wr(8'h00, 32'h1);
		pulse(7'h02);
		rdc(8'h1C, 32'hF, 32'h5);
		grp(3'h1, 8'h14, 4'h5);
		chk(obsGap >= 40 && obsGap <= 48, 1'b1);
		chk(leds[0], 1'b0);
		pulse(7'h01);
		rdc(8'h1C, 32'hF, 32'h3);
		grp(3'h1, 8'h14, 4'h3);
		wr(8'h08, 32'h4);
		rdc(8'h1C, 32'hF, 32'h3);
		wr(8'h0C, 32'h3);
		rdc(8'h1C, 32'hF, 32'hB);
		for (int i = 3; i < 7; i++) begin
			wr(8'h0C, 32'h7F);
			pulse(sled_err_t'(1 << i));
			rdc(8'h1C, 32'hF, 32'hC);
		end
		wr(8'h0C, 32'h7F);
		rdc(8'h08, 32'h7F, 32'h0);
		wr(8'h10, 32'h3);
		wr(8'h18, 32'h6);
		repeat (30) @(posedge clk);
		chk(leds[5:2], 4'h0);
		wr(8'h00, 32'h4);
		repeat (4) @(posedge clk);
		chk(leds[2], 1'b1);
		chk(leds[4], 1'b1);
		wr(8'h10, 32'h1);
		grp(3'h2, 8'h28, 4'h1);
		wr(8'h10, 32'h4);
		grp(3'h2, 8'h28, 4'h3);
		wr(8'h10, 32'h0);
		repeat (300) @(posedge clk);
		watch(2, 2, 1'b0, 0, 0);
		chk(leds[2], 1'b0);
		wr(8'h10, 32'h2);
		watch(2, 2, 1'b0, 4, 12);
		wr(8'h10, 32'h5);
		watch(2, 3, 1'b1, 15, 40);
		for (int i = 0; i < 3; i++) begin
			wr(8'h10, 32'h3 | (32'h10 << i));
			grp(3'h3, 8'h28, 4'(i + 1));
		end
		wr(8'h10, 32'h3);
		wr(8'h14, 32'hFF);
		rdc(8'h1C, 32'h60, 32'h40);
		wr(8'h14, 32'h100);
		rdc(8'h1C, 32'h60, 32'h60);
		watch(3, 3, 1'b0, 0, 0);
		chk(leds[3], 1'b1);
		wr(8'h14, 32'h01000000);
		rdc(8'h1C, 32'h60, 32'h60);
		wr(8'h14, 32'h00800000);
		rdc(8'h1C, 32'h60, 32'h40);
		wr(8'h14, 32'h007F0000);
		rdc(8'h1C, 32'h60, 32'h0);
		for (int i = 1; i < 4; i++) begin
			wr(8'h18, 32'(i));
			grp(3'h4, 8'h28, 4'(i));
		end
		wr(8'h18, 32'h4);
		watch(4, 4, 1'b0, 4, 12);
		wr(8'h18, 32'h5);
		watch(4, 4, 1'b0, 15, 40);
		wr(8'h18, 32'h0);
		repeat (300) @(posedge clk);
		watch(4, 4, 1'b0, 0, 0);
		chk(leds[4], 1'b0);
		wr(8'h18, 32'h10);
		repeat (4) @(posedge clk);
		chk(leds[5], 1'b1);
		wr(8'h18, 32'h0);
		repeat (4) @(posedge clk);
		chk(leds[5], 1'b0);
		results();
	end
endmodule
`default_nettype wire
